// ==== rtcs_map.vh ====
// Register indices, status bit positions, defaults and limits of the RTC
`ifndef RTCS_MAP_VH
`define RTCS_MAP_VH
// Register indices; byte address is four times the index
`define RTCS_IDX_CLK_AREA   16'hea10
`define RTCS_IDX_CLK_BLOCK  16'hea11
`define RTCS_IDX_CLK_WORD   16'hea12
`define RTCS_IDX_ST_AREA    16'hea13
`define RTCS_IDX_ST_BLOCK   16'hea14
`define RTCS_IDX_ST_WORD    16'hea15
`define RTCS_IDX_HW_FAULT   16'hea16
`define RTCS_IDX_DRIFT      16'hea18
`define RTCS_IDX_STATUS     16'hea20
`define RTCS_IDX_SET_TIME   16'hea21
`define RTCS_IDX_SET_DATE   16'hea22
`define RTCS_IDX_SET_PROMPT 16'hea23
`define RTCS_IDX_SET_HOURS  16'hea24
`define RTCS_IDX_DISP_TIME  16'hea25
`define RTCS_IDX_DISP_DATE  16'hea26
`define RTCS_IDX_DISP_HOURS 16'hea27
// Status word bits
`define RTCS_B_CLK_ERR   0
`define RTCS_B_MODE12    1
`define RTCS_B_CLK_REQ   2
`define RTCS_B_STOP_UPD  4
`define RTCS_B_HC_ERR    8
`define RTCS_B_HC_EN     9
`define RTCS_B_HC_REQ    10
`define RTCS_B_PR_ERR    12
`define RTCS_B_PR_HIT    13
`define RTCS_B_PR_REQ    14
`define RTCS_ST_WMASK    16'h463e
`define RTCS_ST_RSVD     16'h88c0
`define RTCS_HW_CORR_BAD 15
// Power-on defaults without backup
`define RTCS_DEF_DAY   8'h01
`define RTCS_DEF_MONTH 8'h04
`define RTCS_DEF_YEAR  8'h5c
`define RTCS_DEF_HOUR  8'h0c
`define RTCS_DEF_WDAY  8'h04
// Limits and timing
`define RTCS_CORR_LIMIT 16'sd400
`define RTCS_HC_MAX     20'd999999
`define RTCS_SEC_PER_HR 12'd3599
`define RTCS_CLK_HZ     25000000
`define RTCS_TICK_S     1
`define RTCS_RESP_DEC   2'b11
`define RTCS_RESP_OK    2'b00
`endif

// ==== rtcs_top.v ====
// Real-time clock status word, settings transfer and system-data registers
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rtcs_map.vh"
module rtcs_top #(
    parameter CLK_HZ = `RTCS_CLK_HZ,
    parameter AW = 18
) (
    input wire aclk,               // System clock
    input wire aresetn,            // Synchronous reset, low
    input wire [AW-1:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid,      // Write address valid
    output reg s_axi_awready,      // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb,  // Write byte strobes
    input wire s_axi_wvalid,       // Write data valid
    output reg s_axi_wready,       // Write data ready
    output reg [1:0] s_axi_bresp,  // Write response
    output reg s_axi_bvalid,       // Write response valid
    input wire s_axi_bready,       // Write response ready
    input wire [AW-1:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid,      // Read address valid
    output reg s_axi_arready,      // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp,  // Read response
    output reg s_axi_rvalid,       // Read data valid
    input wire s_axi_rready,       // Read data ready
    input wire battery_present,    // Backup battery pin
    input wire plc_run,            // Controller in run mode pin
    input wire [1:0] chip_fault,   // Clock chip fault pins
    output reg prompt_reached      // Prompt time reached level
);
    localparam [31:0] TICK_CYC = CLK_HZ * `RTCS_TICK_S;

    // ==============================================================
    // Pin synchronisers
    // ==============================================================
    // Battery pipe is not reset so its level is seen during reset
    reg batt_meta, batt_s;
    reg run_meta, run_s;
    reg [1:0] flt_meta, flt_s;
    always @(posedge aclk) begin
        batt_meta <= battery_present;
        batt_s <= batt_meta;
        run_meta <= plc_run;
        run_s <= run_meta;
        flt_meta <= chip_fault;
        flt_s <= flt_meta;
    end

    // ==============================================================
    // State
    // ==============================================================
    reg [7:0] clk_area_reg, clk_blk_reg, clk_word_reg;
    reg [7:0] st_area_reg, st_blk_reg, st_word_reg;
    reg [15:0] drift_reg, status_reg, hw_reg;
    reg [31:0] set_time_reg, set_date_reg, set_prompt_reg, set_hours_reg;
    reg [31:0] disp_time_reg, disp_date_reg;
    reg [7:0] sec_reg, min_reg, hour_reg, day_reg, mon_reg, year_reg;
    reg [7:0] wday_reg;
    reg [19:0] hours_reg;
    reg [11:0] hsub_reg;
    reg [31:0] presc_reg;
    reg boot_reg;
    reg aw_hold, w_hold;
    reg [AW-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    // Days in a month, leap year every fourth year
    function [7:0] dim;
        input [7:0] m;
        input [7:0] y;
        begin
            case (m)
                8'h02: dim = (y[1:0] == 2'b00) ? 8'h1d : 8'h1c;
                8'h04, 8'h06, 8'h09, 8'h0b: dim = 8'h1e;
                default: dim = 8'h1f;
            endcase
        end
    endfunction

    // Byte strobes to a bit mask
    function [31:0] smask;
        input [3:0] s;
        begin
            smask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    // ==============================================================
    // Setting checks
    // ==============================================================
    wire time_ok = (set_time_reg[7:0] < 8'h3c) &&
        (set_time_reg[15:8] < 8'h3c) && (set_time_reg[23:16] < 8'h18);
    wire [7:0] sd_day = set_date_reg[7:0];
    wire [7:0] sd_mon = set_date_reg[15:8];
    wire [7:0] sd_year = set_date_reg[23:16];
    wire [7:0] sd_wday = set_date_reg[31:24];
    wire date_ok = (sd_day != 8'h00) && (sd_day <= dim(sd_mon, sd_year)) &&
        (sd_mon != 8'h00) && (sd_mon < 8'h0d) && (sd_year < 8'h64) &&
        (sd_wday != 8'h00) && (sd_wday < 8'h08);
    wire prompt_ok = (set_prompt_reg[7:0] < 8'h3c) &&
        (set_prompt_reg[15:8] < 8'h3c) && (set_prompt_reg[23:16] < 8'h18);
    wire hours_ok = set_hours_reg[19:0] <= `RTCS_HC_MAX;
    // Requests wait while the chip reports a fault
    wire chip_good = (hw_reg[1:0] == 2'b00);
    wire clk_take = status_reg[`RTCS_B_CLK_REQ] && chip_good;
    wire pr_take = status_reg[`RTCS_B_PR_REQ] && chip_good;
    wire hc_take = status_reg[`RTCS_B_HC_REQ] && chip_good;
    wire clk_good = time_ok && date_ok;

    // ==============================================================
    // Second tick with drift correction
    // ==============================================================
    // Out-of-range correction is flagged and not applied
    wire signed [15:0] corr = drift_reg;
    wire corr_bad = (corr > `RTCS_CORR_LIMIT) || (corr < -`RTCS_CORR_LIMIT);
    wire [31:0] corr_ext = hw_reg[`RTCS_HW_CORR_BAD] ? 32'h0 :
        {{16{drift_reg[15]}}, drift_reg};
    wire [31:0] period = TICK_CYC + corr_ext;
    wire tick = (presc_reg >= period - 32'h1);

    // ==============================================================
    // AXI write path
    // ==============================================================
    wire wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    wire [15:0] widx = awaddr_reg[17:2];
    wire [31:0] wm = smask(wstrb_reg);
    wire set_wr_ok = run_s || status_reg[`RTCS_B_STOP_UPD];
    wire wr_st = wr_fire && (widx == `RTCS_IDX_STATUS);
    reg w_known;

    // Decode of known indices, read-only ones included
    always @* begin
        case (widx)
            `RTCS_IDX_CLK_AREA, `RTCS_IDX_CLK_BLOCK, `RTCS_IDX_CLK_WORD,
            `RTCS_IDX_ST_AREA, `RTCS_IDX_ST_BLOCK, `RTCS_IDX_ST_WORD,
            `RTCS_IDX_HW_FAULT, `RTCS_IDX_DRIFT, `RTCS_IDX_STATUS,
            `RTCS_IDX_SET_TIME, `RTCS_IDX_SET_DATE, `RTCS_IDX_SET_PROMPT,
            `RTCS_IDX_SET_HOURS, `RTCS_IDX_DISP_TIME, `RTCS_IDX_DISP_DATE,
            `RTCS_IDX_DISP_HOURS: w_known = 1'b1;
            default: w_known = 1'b0;
        endcase
    end

    // Address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RTCS_RESP_OK;
            awaddr_reg <= {AW{1'b0}};
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_hold <= 1'b0;
            end else if (!aw_hold) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_hold <= 1'b0;
            end else if (!w_hold) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_known ? `RTCS_RESP_OK : `RTCS_RESP_DEC;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==============================================================
    // Status word next value
    // ==============================================================
    // Hardware set wins over clear; a software request raised in the
    // same cycle as the hardware clear survives
    wire [15:0] st_sw = wr_st ? ((status_reg & ~(wm[15:0] &
        `RTCS_ST_WMASK)) | (wdata_reg[15:0] & wm[15:0] &
        `RTCS_ST_WMASK)) : status_reg;
    wire [15:0] st_wset = wr_st ? (wdata_reg[15:0] & wm[15:0] &
        `RTCS_ST_WMASK) : 16'h0;
    wire [15:0] cur_hms = {hour_reg, min_reg};
    wire pr_hit = tick && (set_prompt_reg[23:0] ==
        {hour_reg, min_reg, sec_reg});
    reg [15:0] hw_clr, hw_set;
    always @* begin
        hw_clr = 16'h0;
        hw_set = 16'h0;
        hw_clr[`RTCS_B_CLK_REQ] = clk_take;
        hw_clr[`RTCS_B_PR_REQ] = pr_take;
        hw_clr[`RTCS_B_HC_REQ] = hc_take;
        hw_set[`RTCS_B_CLK_ERR] = clk_take && !clk_good;
        hw_clr[`RTCS_B_CLK_ERR] = clk_take && clk_good;
        hw_set[`RTCS_B_PR_ERR] = pr_take && !prompt_ok;
        hw_clr[`RTCS_B_PR_ERR] = pr_take && prompt_ok;
        hw_set[`RTCS_B_HC_ERR] = hc_take && !hours_ok;
        hw_clr[`RTCS_B_HC_ERR] = hc_take && hours_ok;
        hw_set[`RTCS_B_PR_HIT] = pr_hit;
        hw_clr[`RTCS_B_PR_HIT] = pr_take && prompt_ok;
    end
    wire [15:0] status_next = (((st_sw & ~hw_clr) | hw_set | st_wset) &
        ~`RTCS_ST_RSVD);

    // ==============================================================
    // Registers written by software and status
    // ==============================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_area_reg <= 8'h0;
            clk_blk_reg <= 8'h0;
            clk_word_reg <= 8'h0;
            st_area_reg <= 8'h0;
            st_blk_reg <= 8'h0;
            st_word_reg <= 8'h0;
            drift_reg <= 16'h0;
            status_reg <= 16'h0;
            hw_reg <= 16'h0;
            set_time_reg <= 32'h0;
            set_date_reg <= 32'h0;
            set_prompt_reg <= 32'h0;
            set_hours_reg <= 32'h0;
            prompt_reached <= 1'b0;
        end else begin
            status_reg <= status_next;
            prompt_reached <= status_next[`RTCS_B_PR_HIT];
            hw_reg <= {corr_bad, 13'h0, flt_s};
            if (wr_fire) begin
                // Placement codes are stored as given by software
                case (widx)
                    `RTCS_IDX_CLK_AREA: clk_area_reg <= wm[0] ?
                        wdata_reg[7:0] : clk_area_reg;
                    `RTCS_IDX_CLK_BLOCK: clk_blk_reg <= wm[0] ?
                        wdata_reg[7:0] : clk_blk_reg;
                    `RTCS_IDX_CLK_WORD: clk_word_reg <= wm[0] ?
                        wdata_reg[7:0] : clk_word_reg;
                    `RTCS_IDX_ST_AREA: st_area_reg <= wm[0] ?
                        wdata_reg[7:0] : st_area_reg;
                    `RTCS_IDX_ST_BLOCK: st_blk_reg <= wm[0] ?
                        wdata_reg[7:0] : st_blk_reg;
                    `RTCS_IDX_ST_WORD: st_word_reg <= wm[0] ?
                        wdata_reg[7:0] : st_word_reg;
                    `RTCS_IDX_DRIFT: drift_reg <= (drift_reg & ~wm[15:0]) |
                        (wdata_reg[15:0] & wm[15:0]);
                    `RTCS_IDX_SET_TIME: if (set_wr_ok) set_time_reg <=
                        (set_time_reg & ~wm) | (wdata_reg & wm);
                    `RTCS_IDX_SET_DATE: if (set_wr_ok) set_date_reg <=
                        (set_date_reg & ~wm) | (wdata_reg & wm);
                    `RTCS_IDX_SET_PROMPT: if (set_wr_ok) set_prompt_reg <=
                        (set_prompt_reg & ~wm) | (wdata_reg & wm);
                    `RTCS_IDX_SET_HOURS: if (set_wr_ok) set_hours_reg <=
                        (set_hours_reg & ~wm) | (wdata_reg & wm);
                    default: ;
                endcase
            end
        end
    end

    // ==============================================================
    // Time keeping
    // ==============================================================
    // With a battery the time survives reset; the divider, hours counter and display copies restart.
    // Defaults load again in the first cycle after reset, since the
    // battery level is only settled two edges into reset.
    always @(posedge aclk) begin
        if ((!aresetn || boot_reg) && !batt_s) begin
            sec_reg <= 8'h00;
            min_reg <= 8'h00;
            hour_reg <= `RTCS_DEF_HOUR;
            day_reg <= `RTCS_DEF_DAY;
            mon_reg <= `RTCS_DEF_MONTH;
            year_reg <= `RTCS_DEF_YEAR;
            wday_reg <= `RTCS_DEF_WDAY;
        end else if (!aresetn) begin
            sec_reg <= sec_reg;
        end else if (clk_take && clk_good) begin
            sec_reg <= set_time_reg[7:0];
            min_reg <= set_time_reg[15:8];
            hour_reg <= set_time_reg[23:16];
            day_reg <= sd_day;
            mon_reg <= sd_mon;
            year_reg <= sd_year;
            wday_reg <= sd_wday;
        end else if (tick) begin
            sec_reg <= (sec_reg == 8'h3b) ? 8'h00 : sec_reg + 8'h01;
            if (sec_reg == 8'h3b) begin
                min_reg <= (min_reg == 8'h3b) ? 8'h00 : min_reg + 8'h01;
                if (min_reg == 8'h3b) begin
                    hour_reg <= (hour_reg == 8'h17) ? 8'h00 :
                        hour_reg + 8'h01;
                    if (hour_reg == 8'h17) begin
                        wday_reg <= (wday_reg == 8'h07) ? 8'h01 :
                            wday_reg + 8'h01;
                        if (day_reg >= dim(mon_reg, year_reg)) begin
                            day_reg <= 8'h01;
                            mon_reg <= (mon_reg == 8'h0c) ? 8'h01 :
                                mon_reg + 8'h01;
                            if (mon_reg == 8'h0c)
                                year_reg <= (year_reg == 8'h63) ? 8'h00 :
                                    year_reg + 8'h01;
                        end else begin
                            day_reg <= day_reg + 8'h01;
                        end
                    end
                end
            end
        end
    end

    // Divider, hours counter and refreshed display copies
    always @(posedge aclk) begin
        if (!aresetn) begin
            presc_reg <= 32'h0;
            boot_reg <= 1'b1;
            hours_reg <= 20'h0;
            hsub_reg <= 12'h0;
            disp_time_reg <= 32'h0;
            disp_date_reg <= 32'h0;
        end else begin
            boot_reg <= 1'b0;
            presc_reg <= (tick || (clk_take && clk_good)) ? 32'h0 :
                presc_reg + 32'h1;
            if (hc_take && hours_ok) begin
                hours_reg <= set_hours_reg[19:0];
                hsub_reg <= 12'h0;
            end else if (tick && status_reg[`RTCS_B_HC_EN]) begin
                hsub_reg <= (hsub_reg == `RTCS_SEC_PER_HR) ? 12'h0 :
                    hsub_reg + 12'h1;
                if (hsub_reg == `RTCS_SEC_PER_HR)
                    hours_reg <= (hours_reg == `RTCS_HC_MAX) ? 20'h0 :
                        hours_reg + 20'h1;
            end
            if (tick) begin
                disp_time_reg <= {8'h00, hour_reg, min_reg, sec_reg};
                disp_date_reg <= {wday_reg, year_reg, mon_reg, day_reg};
            end
        end
    end

    // ==============================================================
    // AXI read path
    // ==============================================================
    wire [15:0] ridx = s_axi_araddr[17:2];
    reg [31:0] rd_data;
    reg rd_err;
    always @* begin
        rd_err = 1'b0;
        case (ridx)
            `RTCS_IDX_CLK_AREA: rd_data = {24'h0, clk_area_reg};
            `RTCS_IDX_CLK_BLOCK: rd_data = {24'h0, clk_blk_reg};
            `RTCS_IDX_CLK_WORD: rd_data = {24'h0, clk_word_reg};
            `RTCS_IDX_ST_AREA: rd_data = {24'h0, st_area_reg};
            `RTCS_IDX_ST_BLOCK: rd_data = {24'h0, st_blk_reg};
            `RTCS_IDX_ST_WORD: rd_data = {24'h0, st_word_reg};
            `RTCS_IDX_HW_FAULT: rd_data = {16'h0, hw_reg};
            `RTCS_IDX_DRIFT: rd_data = {16'h0, drift_reg};
            `RTCS_IDX_STATUS: rd_data = {16'h0, status_reg};
            `RTCS_IDX_SET_TIME: rd_data = set_time_reg;
            `RTCS_IDX_SET_DATE: rd_data = set_date_reg;
            `RTCS_IDX_SET_PROMPT: rd_data = set_prompt_reg;
            `RTCS_IDX_SET_HOURS: rd_data = set_hours_reg;
            `RTCS_IDX_DISP_TIME: rd_data = disp_time_reg;
            `RTCS_IDX_DISP_DATE: rd_data = disp_date_reg;
            `RTCS_IDX_DISP_HOURS: rd_data = {12'h0, hours_reg};
            default: begin
                rd_data = 32'h0;
                rd_err = 1'b1;
            end
        endcase
    end

    // One read at a time; data captured at address acceptance
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RTCS_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `RTCS_RESP_DEC : `RTCS_RESP_OK;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
    wire unused_ok = &{1'b0, cur_hms};
endmodule // rtcs_top

// ==== rtcs_checker.sv ====
// Register bus protocol checker for the RTC status block
`timescale 1ns/1ps
`include "rtcs_map.vh"
module rtcs_chk #(
    parameter AW = 18
) (
    input wire aclk, // Clock
    input wire aresetn, // Reset, low
    input wire [AW-1:0] s_axi_awaddr, // Write addr
    input wire s_axi_awvalid, // Aw valid
    input wire s_axi_awready, // Aw ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire [1:0] s_axi_bresp, // B resp
    input wire s_axi_bvalid, // B valid
    input wire s_axi_bready, // B ready
    input wire [AW-1:0] s_axi_araddr, // Read addr
    input wire s_axi_arvalid, // Ar valid
    input wire s_axi_arready, // Ar ready
    input wire [31:0] s_axi_rdata, // R data
    input wire [1:0] s_axi_rresp, // R resp
    input wire s_axi_rvalid, // R valid
    input wire s_axi_rready, // R ready
    input wire prompt_reached // Prompt flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Map decode; gaps in the index space must answer with a decode error
    function automatic bit hit(input logic [AW-1:0] a);
        logic [15:0] i;
        i = a[AW-1:2];
        hit = (i >= `RTCS_IDX_CLK_AREA && i <= `RTCS_IDX_HW_FAULT) ||
            i == `RTCS_IDX_DRIFT ||
            (i >= `RTCS_IDX_STATUS && i <= `RTCS_IDX_DISP_HOURS);
    endfunction
    // Address and data taken together, and read address taken
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: // Response two cycles after the take
        assert property (s_wr |-> ##2 s_axi_bvalid) else $error("no bvalid");
    a_rd_answer: // Read data one cycle after the take
        assert property (s_rd |=> s_axi_rvalid && !s_axi_arready)
        else $error("no rvalid");
    a_b_hold: // Response stands until accepted
        assert property (s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_r_hold: // Read data stands until accepted
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_b_drop: // One response per write
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_unmapped_rd: // Gap reads give decode error and zero
        assert property (s_rd ##0 !hit(s_axi_araddr) |=>
            s_axi_rresp == `RTCS_RESP_DEC && s_axi_rdata == 32'h0)
        else $error("bad unmapped read");
    a_unmapped_wr: // Gap writes give decode error
        assert property (s_wr ##0 !hit(s_axi_awaddr) |-> ##2
            s_axi_bresp == `RTCS_RESP_DEC) else $error("bad unmapped write");
    a_mapped_wr: // Mapped writes answer okay
        assert property (s_wr ##0 hit(s_axi_awaddr) |-> ##2
            s_axi_bresp == `RTCS_RESP_OK) else $error("bad mapped write");
    a_reset_quiet: // Outputs low coming out of reset
        assert property ($rose(aresetn) |->
            !s_axi_bvalid && !s_axi_rvalid && !prompt_reached)
        else $error("outputs active after reset");
endmodule // rtcs_chk
bind rtcs_top rtcs_chk #(.AW(AW)) chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .prompt_reached(prompt_reached));

// ==== tb_top.sv ====
// Register-level testbench for the RTC status block
`timescale 1ns/1ps
`include "rtcs_map.vh"
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
    logic arv = 1'b0, rrdy = 1'b0, run = 1'b1, prompt, awr, wrdy, bv, arr, rv;
    logic [17:0] awa = 18'h0, ara = 18'h0;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] flt = 2'h0, bresp, rresp, r;
    logic [15:0] dv [4] = '{16'h0190, 16'hfe70, 16'h0191, 16'hfe6f};
    int miscompares = 0, tests_run = 0;
    // 25 MHz clock
    always #20 aclk = ~aclk;
    // Short second so prompt and display ticks fit the run
    rtcs_top #(.CLK_HZ(20)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy), .battery_present(1'b0),
        .plc_run(run), .chip_fault(flt), .prompt_reached(prompt));
    // ==========================================
    // Bus tasks and comparison
    task automatic chk(input logic [33:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Each channel is released only at the edge where it was taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] v);
        @(posedge aclk);
        awa <= {idx, 2'b00};
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        while (!(bv && brdy)) begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end
        r = bresp;
        brdy <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx);
        @(posedge aclk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rrdy <= 1'b1;
        while (!(rv && rrdy)) begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
        end
        d = rdat;
        r = rresp;
        rrdy <= 1'b0;
    endtask
    task automatic rc(input logic [15:0] idx, input logic [31:0] m, e);
        rd(idx);
        chk({2'h0, d & m}, {2'h0, e});
    endtask
    task automatic summarize;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        int n;
        // Reset held for two clock cycles
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`RTCS_IDX_STATUS, 32'hffff, 32'h0);
        // First second tick copies the default time to the display
        repeat (20) @(posedge aclk);
        rc(`RTCS_IDX_DISP_TIME, 32'hffffff, 32'h0c0000);
        rc(`RTCS_IDX_DISP_DATE, 32'hffffffff, 32'h045c0401);
        wr(16'hea17, 32'h1);
        chk({32'h0, r}, {32'h0, `RTCS_RESP_DEC});
        rd(16'hea17);
        chk({r, d}, {`RTCS_RESP_DEC, 32'h0});
        wr(`RTCS_IDX_CLK_AREA, 32'h44);
        wr(`RTCS_IDX_CLK_BLOCK, 32'h02);
        wr(`RTCS_IDX_ST_WORD, 32'hff);
        rc(`RTCS_IDX_CLK_AREA, 32'hffffffff, 32'h44);
        rc(`RTCS_IDX_CLK_BLOCK, 32'hffffffff, 32'h02);
        rc(`RTCS_IDX_ST_WORD, 32'hffffffff, 32'hff);
        $display("reset and map test done");
        // Drift limits at both edges, with a faulty chip reported
        flt <= 2'h2;
        for (int i = 0; i < 4; i++) begin
            wr(`RTCS_IDX_DRIFT, {16'h0, dv[i]});
            rc(`RTCS_IDX_DRIFT, 32'hffff, {16'h0, dv[i]});
            rc(`RTCS_IDX_HW_FAULT, 32'h8003,
                {16'h0, i[1], 15'h2});
        end
        wr(`RTCS_IDX_HW_FAULT, 32'h0);
        rc(`RTCS_IDX_HW_FAULT, 32'h8003, 32'h8002);
        wr(`RTCS_IDX_DRIFT, 32'h0);
        flt <= 2'h0;
        $display("hardware status test done");
        // Reserved bits, then hours counter reject and accept
        wr(`RTCS_IDX_STATUS, 32'h88c0);
        rc(`RTCS_IDX_STATUS, 32'hffff, 32'h0);
        wr(`RTCS_IDX_SET_HOURS, 32'd1000000);
        wr(`RTCS_IDX_STATUS, 32'h0600);
        rc(`RTCS_IDX_STATUS, 32'hffff, 32'h0300);
        wr(`RTCS_IDX_SET_HOURS, 32'd999999);
        wr(`RTCS_IDX_STATUS, 32'h0600);
        rc(`RTCS_IDX_STATUS, 32'hffff, 32'h0200);
        rc(`RTCS_IDX_DISP_HOURS, 32'hfffff, 32'd999999);
        $display("hours counter test done");
        // Prompt reject, then a prompt two seconds after a fresh time
        wr(`RTCS_IDX_SET_PROMPT, 32'h00180000);
        wr(`RTCS_IDX_STATUS, 32'h4200);
        rc(`RTCS_IDX_STATUS, 32'hffff, 32'h1200);
        wr(`RTCS_IDX_SET_TIME, 32'h000c0000);
        wr(`RTCS_IDX_SET_DATE, 32'h045c0401);
        wr(`RTCS_IDX_SET_PROMPT, 32'h000c0002);
        wr(`RTCS_IDX_STATUS, 32'h4204);
        rc(`RTCS_IDX_STATUS, 32'hffff, 32'h0200);
        chk({33'h0, prompt}, 34'h0);
        for (n = 0; n < 200 && prompt !== 1'b1; n++) @(posedge aclk);
        chk({33'h0, prompt}, 34'h1);
        rc(`RTCS_IDX_STATUS, 32'h2000, 32'h2000);
        rc(`RTCS_IDX_DISP_TIME, 32'hffffff, 32'h0c0002);
        $display("prompt test done");
        // Stopped controller: settings only land with bit 4 set
        run <= 1'b0;
        wr(`RTCS_IDX_SET_HOURS, 32'd1000000);
        wr(`RTCS_IDX_STATUS, 32'h0600);
        rc(`RTCS_IDX_STATUS, 32'h0700, 32'h0200);
        wr(`RTCS_IDX_STATUS, 32'h0210);
        wr(`RTCS_IDX_SET_HOURS, 32'd1000000);
        wr(`RTCS_IDX_STATUS, 32'h0610);
        rc(`RTCS_IDX_STATUS, 32'h0700, 32'h0300);
        $display("stop mode test done");
        summarize();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        summarize();
    end
endmodule // tb_top
